// ---- bench/spdep_bus_master.sv ----
// two-wire bus master model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
module spdep_bus_master
(
   // system clock for pacing
   input wire logic clk_in,
   // bus lines
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   // bus clock stands high and data is released between frames
   initial
   begin
      scl_out = 1'h1;
      sda_low_out = 1'h0;
   end

   task automatic half();
      repeat (4) @(negedge clk_in);
   endtask

   task automatic start();
      sda_low_out = 1'h0;
      half();
      sda_low_out = 1'h1;
      half();
      scl_out = 1'h0;
   endtask

   // msb first, ninth clock released for acknowledge
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         @(negedge clk_in);
         sda_low_out = (i > 0) ? ~b[i - 1] : 1'h0;
         repeat (3) @(negedge clk_in);
         scl_out = 1'h1;
         repeat (2) @(negedge clk_in);
         ack = ~sda_in;
         repeat (2) @(negedge clk_in);
         scl_out = 1'h0;
      end
   endtask

   // stop: data rises while clock high
   task automatic stop();
      @(negedge clk_in);
      sda_low_out = 1'h1;
      repeat (3) @(negedge clk_in);
      scl_out = 1'h1;
      half();
      sda_low_out = 1'h0;
      half();
   endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the eeprom two-wire slave
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("wrong value %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb_top;
   logic clk_in;
   logic rst_in;
   logic wp;
   logic elev;
   logic perm;
   logic rev;
   logic prog_ready;
   logic [2:0] strap;
   logic scl;
   logic sda_low;
   logic sda_o;
   logic sda_oe;
   logic set_p;
   logic set_r;
   logic clr_r;
   logic pv;
   logic busy;
   logic [7:0] pa;
   logic [7:0] pd;
   logic [7:0] qa[$];
   logic [7:0] qd[$];
   logic [2:0] ac;
   int checked = 0;
   int fail_count = 0;
   // pulled-up open-drain data line
   wire sda = ~(sda_low | (sda_oe & ~sda_o));

   spdep_slave #(.WRITE_CYCLES(20)) u_spdep_slave (.clk_in(clk_in), .rst_in(rst_in),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .strap_bit0_in(strap[0]), .strap_bit1_in(strap[1]), .strap_bit2_in(strap[2]),
      .elevated_strap_voltage_in(elev), .write_protect_in(wp), .permanent_lock_in(perm),
      .reversible_lock_in(rev), .set_permanent_lock_out(set_p),
      .set_reversible_lock_out(set_r), .clear_reversible_lock_out(clr_r),
      .prog_valid_out(pv), .prog_ready_in(prog_ready), .prog_addr_out(pa),
      .prog_data_out(pd), .busy_out(busy));
   spdep_bus_master u_spdep_bus_master (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
      .sda_low_out(sda_low));

   initial
   begin
      clk_in = 1'h0;
      forever #20 clk_in = ~clk_in;
   end

   // lock flags live outside the block and only move on its pulses
   always @(posedge clk_in)
   begin
      if (set_p)
         perm <= 1'h1;
      if (set_r)
         rev <= 1'h1;
      if (clr_r)
         rev <= 1'h0;
      if (pv && prog_ready)
      begin
         qa.push_back(pa);
         qd.push_back(pd);
      end
   end

   task automatic xfer(input logic [7:0] dev, input logic [7:0] wa, input int n,
      input logic [7:0] d0);
      logic a;
      qa.delete();
      qd.delete();
      ac = 3'h0;
      u_spdep_bus_master.start();
      u_spdep_bus_master.send_byte(dev, a);
      ac[0] = a;
      u_spdep_bus_master.send_byte(wa, a);
      ac[1] = a;
      for (int i = 0; i < n; i++)
      begin
         u_spdep_bus_master.send_byte(d0 + 8'(i), a);
         ac[2] = a;
      end
      u_spdep_bus_master.stop();
   endtask

   task automatic settle();
      int k;
      k = 0;
      repeat (8) @(negedge clk_in);
      while (busy !== 1'h0 && k < 4000)
      begin
         @(negedge clk_in);
         k++;
      end
      `CHK("busy", 1'h0, busy)
   endtask

   function automatic logic [7:0] mdev(input logic rw);
      return {spdep_pkg::MEM_CODE, strap, rw};
   endfunction

   task automatic t_byte();
      logic a;
      strap = 3'h5;
      xfer(mdev(1'h0), 8'h35, 1, 8'ha5);
      settle();
      `CHK("byte acks", 3'h7, ac)
      `CHK("byte count", 1, qa.size())
      `CHK("byte addr", 8'h35, qa[0])
      `CHK("byte data", 8'ha5, qd[0])
      xfer({spdep_pkg::MEM_CODE, ~strap, 1'h0}, 8'h35, 1, 8'h11);
      settle();
      `CHK("strap miss acks", 3'h0, ac)
      `CHK("strap miss count", 0, qa.size())
      u_spdep_bus_master.start();
      u_spdep_bus_master.send_byte(mdev(1'h1), a);
      u_spdep_bus_master.stop();
      `CHK("read addr ack", 1'h1, a)
      xfer(mdev(1'h0), 8'h36, 1, 8'h5a);
      settle();
      `CHK("after read acks", 3'h7, ac)
   endtask

   task automatic t_page();
      logic a;
      logic [3:0] j;
      strap = 3'h2;
      prog_ready = 1'h0;
      xfer(mdev(1'h0), 8'h8e, 18, 8'h40);
      `CHK("page acks", 3'h7, ac)
      u_spdep_bus_master.start();
      u_spdep_bus_master.send_byte(mdev(1'h1), a);
      u_spdep_bus_master.stop();
      `CHK("busy ack", 1'h0, a)
      prog_ready = 1'h1;
      settle();
      `CHK("page count", 16, qa.size())
      for (int k = 0; k < qa.size(); k++)
      begin
         j = qa[k][3:0] - 4'he;
         `CHK("page hi", 4'h8, qa[k][7:4])
         `CHK("page data", 8'h40 + ((j < 4'h2) ? 8'(j) + 8'h10 : 8'(j)), qd[k])
      end
   endtask

   task automatic t_wp();
      // protect level held from start to stop
      wp = 1'h1;
      xfer(mdev(1'h0), 8'ha0, 1, 8'h33);
      settle();
      `CHK("wp acks", 3'h3, ac)
      `CHK("wp count", 0, qa.size())
      elev = 1'h1;
      strap = 3'h1;
      xfer({spdep_pkg::PROT_CODE, spdep_pkg::SET_REV_SEL, 1'h0}, 8'h00, 1, 8'h00);
      settle();
      `CHK("wp lock acks", 3'h3, ac)
      `CHK("wp lock flag", 1'h0, rev)
      wp = 1'h0;
   endtask

   task automatic t_locks();
      // elevated level on strap 0 for the reversible commands
      elev = 1'h1;
      strap = 3'h1;
      xfer({spdep_pkg::PROT_CODE, spdep_pkg::SET_REV_SEL, 1'h0}, 8'h00, 1, 8'h00);
      settle();
      `CHK("set rev acks", 3'h7, ac)
      `CHK("set rev flag", 1'h1, rev)
      xfer({spdep_pkg::PROT_CODE, spdep_pkg::SET_REV_SEL, 1'h0}, 8'h00, 1, 8'h00);
      settle();
      `CHK("set rev again acks", 3'h0, ac)
      elev = 1'h0;
      xfer(mdev(1'h0), 8'h10, 2, 8'h77);
      settle();
      `CHK("low acks", 3'h3, ac)
      `CHK("low count", 0, qa.size())
      xfer(mdev(1'h0), 8'h90, 1, 8'h66);
      settle();
      `CHK("high acks", 3'h7, ac)
      `CHK("high addr", 8'h90, qa[0])
      elev = 1'h1;
      strap = 3'h3;
      xfer({spdep_pkg::PROT_CODE, spdep_pkg::CLR_REV_SEL, 1'h0}, 8'h00, 1, 8'h00);
      settle();
      `CHK("clr rev flag", 1'h0, rev)
      elev = 1'h0;
      strap = 3'h6;
      xfer({spdep_pkg::PROT_CODE, strap, 1'h0}, 8'h00, 1, 8'h00);
      settle();
      `CHK("perm acks", 3'h7, ac)
      `CHK("perm flag", 1'h1, perm)
      xfer(mdev(1'h0), 8'h05, 1, 8'h12);
      settle();
      `CHK("perm low acks", 3'h3, ac)
      `CHK("perm low count", 0, qa.size())
      xfer({spdep_pkg::PROT_CODE, strap, 1'h0}, 8'h00, 1, 8'h00);
      settle();
      `CHK("perm code acks", 3'h0, ac)
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      rst_in = 1'h1;
      wp = 1'h0;
      elev = 1'h0;
      perm = 1'h0;
      rev = 1'h0;
      prog_ready = 1'h1;
      strap = 3'h0;
      repeat (20) @(negedge clk_in);
      rst_in = 1'h0;
      // wait out the internal power-on clear
      repeat (30) @(negedge clk_in);
      t_byte();
      t_page();
      t_wp();
      t_locks();
      tally_and_finish();
   end

   // bounded well above the expected few hundred microseconds
   initial
   begin
      #2000000;
      fail_count++;
      tally_and_finish();
   end
endmodule

// ---- hdl/spdep_buf.sv ----
// two-entry valid/ready buffer on the received-byte path
`timescale 1ns/1ps
module spdep_buf
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [7:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [7:0] out_data_out
);
   logic [7:0] mem [0:spdep_pkg::BUF_DEPTH-1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   assign in_ready_out = (count != 2'h2);
   assign out_valid_out = (count != 2'h0);
   assign out_data_out = mem[rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (push)
         mem[wr_ptr] <= in_data_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// ---- hdl/spdep_pkg.sv ----
// package: constants shared by the eeprom two-wire slave
package spdep_pkg;
   localparam logic [3:0] MEM_CODE = 4'ha;
   localparam logic [3:0] PROT_CODE = 4'h6;
   localparam logic [2:0] SET_REV_SEL = 3'h1;
   localparam logic [2:0] CLR_REV_SEL = 3'h3;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_BITS = 4;
   localparam int BYTE_BITS = 8;
   localparam int LOWER_BIT = 7;
   localparam int CLK_HZ = 25000000;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYCLES = (CLK_HZ / 1000000) * WRITE_TIME_US;
   localparam int POR_CYCLES = 16;
   localparam int BUF_DEPTH = 2;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_DEVADDR = 3'h1,
      ST_WORDADDR = 3'h2,
      ST_DATA = 3'h3,
      ST_READ = 3'h4,
      ST_IGNORE = 3'h5
   } spdep_state_t;
   typedef enum logic [1:0]
   {
      CMD_MEM = 2'h0,
      CMD_SETREV = 2'h1,
      CMD_CLRREV = 2'h2,
      CMD_PERM = 2'h3
   } spdep_cmd_t;
endpackage

// ---- hdl/spdep_slave.sv ----
// two-wire slave front end of a 256x8 presence-detect eeprom with write protection
`timescale 1ns/1ps
module spdep_slave
#(
   parameter int WRITE_CYCLES = spdep_pkg::WRITE_CYCLES
)
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // straps and protection pins
   input wire logic strap_bit0_in,
   input wire logic strap_bit1_in,
   input wire logic strap_bit2_in,
   input wire logic elevated_strap_voltage_in,
   input wire logic write_protect_in,
   // lock state (nonvolatile, kept by the array side)
   input wire logic permanent_lock_in,
   input wire logic reversible_lock_in,
   output logic set_permanent_lock_out,
   output logic set_reversible_lock_out,
   output logic clear_reversible_lock_out,
   // page programming stream
   output logic prog_valid_out,
   input wire logic prog_ready_in,
   output logic [7:0] prog_addr_out,
   output logic [7:0] prog_data_out,
   output logic busy_out
);
   spdep_pkg::spdep_state_t state;
   spdep_pkg::spdep_cmd_t cmd;
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] st_sync;
   logic [1:0] hv_sync;
   logic [1:0] wp_sync;
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic ack_phase;
   logic ack_drive;
   logic [7:0] word_addr;
   logic [7:0] page_mem [0:spdep_pkg::PAGE_BYTES-1];
   logic [spdep_pkg::PAGE_BITS:0] page_count;
   logic [spdep_pkg::PAGE_BITS-1:0] page_start;
   logic write_ok;
   logic [4:0] por_cnt;
   logic por_done;
   logic programming;
   logic [spdep_pkg::PAGE_BITS:0] emit_idx;
   logic [23:0] wcnt;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [7:0] buf_in_data;
   logic [2:0] strap_val;

   function automatic logic lower_half(input logic [7:0] a);
      lower_half = ~a[spdep_pkg::LOWER_BIT];
   endfunction

   // sync all pins; strap pull-downs mean open reads low
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         st_sync <= 2'h0;
         hv_sync <= 2'h0;
         wp_sync <= 2'h0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         st_sync <= {st_sync[0], strap_bit0_in};
         hv_sync <= {hv_sync[0], elevated_strap_voltage_in};
         wp_sync <= {wp_sync[0], write_protect_in};
         scl_q <= scl_sync[1];
         sda_q <= sda_sync[1];
      end
   end

   // strap 1 and 2 are static board straps; sample every cycle through two stages
   logic [1:0] s1_sync;
   logic [1:0] s2_sync;
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s1_sync <= 2'h0;
         s2_sync <= 2'h0;
      end
      else
      begin
         s1_sync <= {s1_sync[0], strap_bit1_in};
         s2_sync <= {s2_sync[0], strap_bit2_in};
      end
   end
   assign strap_val = {s2_sync[1], s1_sync[1], st_sync[1]};

   assign scl_rise = scl_sync[1] && !scl_q;
   assign scl_fall = !scl_sync[1] && scl_q;
   assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
   assign stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         por_cnt <= 5'h0;
      else if (!por_done)
         por_cnt <= por_cnt + 5'h1;
   end
   assign por_done = (por_cnt == 5'(spdep_pkg::POR_CYCLES));

   // protocol state machine
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !por_done)
      begin
         state <= spdep_pkg::ST_IDLE;
         cmd <= spdep_pkg::CMD_MEM;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         ack_phase <= 1'b0;
         ack_drive <= 1'b0;
         word_addr <= 8'h00;
         page_count <= '0;
         page_start <= '0;
         write_ok <= 1'b0;
      end
      else if (programming)
      begin
         state <= spdep_pkg::ST_IDLE;
         ack_drive <= 1'b0;
      end
      else if (start_det)
      begin
         state <= spdep_pkg::ST_DEVADDR;
         bit_cnt <= 4'h0;
         ack_phase <= 1'b0;
         ack_drive <= 1'b0;
         page_count <= '0;
      end
      else if (stop_det)
      begin
         state <= spdep_pkg::ST_IDLE;
         ack_drive <= 1'b0;
         ack_phase <= 1'b0;
      end
      else if (state != spdep_pkg::ST_IDLE && state != spdep_pkg::ST_IGNORE)
      begin
         // sample on scl rise, change on scl fall
         if (scl_rise && !ack_phase)
         begin
            shift <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (scl_fall && ack_phase)
         begin
            ack_phase <= 1'b0;
            ack_drive <= 1'b0;
            if (state == spdep_pkg::ST_READ)
               state <= spdep_pkg::ST_IGNORE;
         end
         else if (scl_fall && bit_cnt == 4'(spdep_pkg::BYTE_BITS))
         begin
            bit_cnt <= 4'h0;
            ack_phase <= 1'b1;
            unique case (state)
               spdep_pkg::ST_DEVADDR:
               begin
                  if (shift[7:4] == spdep_pkg::MEM_CODE && shift[3:1] == strap_val)
                  begin
                     ack_drive <= 1'b1;
                     cmd <= spdep_pkg::CMD_MEM;
                     state <= shift[0] ? spdep_pkg::ST_READ : spdep_pkg::ST_WORDADDR;
                  end
                  // no ack to protection code once permanent
                  else if (shift[7:4] == spdep_pkg::PROT_CODE && !permanent_lock_in
                           && !shift[0])
                  begin
                     state <= spdep_pkg::ST_WORDADDR;
                     ack_drive <= 1'b1;
                     if (hv_sync[1] && shift[3:1] == spdep_pkg::SET_REV_SEL)
                     begin
                        // set refused ack when already set
                        cmd <= spdep_pkg::CMD_SETREV;
                        if (reversible_lock_in)
                        begin
                           ack_drive <= 1'b0;
                           state <= spdep_pkg::ST_IGNORE;
                        end
                     end
                     else if (hv_sync[1] && shift[3:1] == spdep_pkg::CLR_REV_SEL)
                        cmd <= spdep_pkg::CMD_CLRREV;
                     else if (shift[3:1] == strap_val)
                        cmd <= spdep_pkg::CMD_PERM;
                     else
                     begin
                        ack_drive <= 1'b0;
                        state <= spdep_pkg::ST_IGNORE;
                     end
                  end
                  else
                     state <= spdep_pkg::ST_IGNORE;
               end
               spdep_pkg::ST_WORDADDR:
               begin
                  // word address taken, value ignored for commands
                  ack_drive <= 1'b1;
                  word_addr <= shift;
                  page_start <= shift[3:0];
                  state <= spdep_pkg::ST_DATA;
               end
               spdep_pkg::ST_DATA:
               begin
                  page_mem[word_addr[3:0]] <= shift;
                  word_addr <= {word_addr[7:4], word_addr[3:0] + 4'h1};
                  if (page_count != 5'(spdep_pkg::PAGE_BYTES))
                     page_count <= page_count + 5'h1;
                  if (cmd == spdep_pkg::CMD_MEM)
                     write_ok <= !wp_sync[1]
                        && !((permanent_lock_in || reversible_lock_in)
                             && lower_half(word_addr));
                  else
                     write_ok <= !wp_sync[1];
                  if (cmd == spdep_pkg::CMD_MEM)
                     ack_drive <= !wp_sync[1]
                        && !((permanent_lock_in || reversible_lock_in)
                             && lower_half(word_addr));
                  else
                     ack_drive <= !wp_sync[1];
               end
               default:
                  ack_drive <= 1'b0;
            endcase
         end
      end
   end

   // stop after data launches programming
   // the stop's own scl rise has already clocked one stray bit into the shifter
   logic launch;
   assign launch = stop_det && !programming && state == spdep_pkg::ST_DATA
                   && page_count != '0 && write_ok && bit_cnt <= 4'h1;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         set_permanent_lock_out <= 1'b0;
         set_reversible_lock_out <= 1'b0;
         clear_reversible_lock_out <= 1'b0;
      end
      else
      begin
         set_permanent_lock_out <= launch && cmd == spdep_pkg::CMD_PERM;
         set_reversible_lock_out <= launch && cmd == spdep_pkg::CMD_SETREV;
         clear_reversible_lock_out <= launch && cmd == spdep_pkg::CMD_CLRREV;
      end
   end

   // programming cycle: drain page, then hold busy for write time
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         programming <= 1'b0;
         emit_idx <= '0;
         wcnt <= 24'h0;
      end
      else if (launch)
      begin
         programming <= 1'b1;
         emit_idx <= (cmd == spdep_pkg::CMD_MEM) ? '0 : page_count;
         wcnt <= 24'h0;
      end
      else if (programming)
      begin
         if (emit_idx != page_count)
         begin
            if (buf_in_ready)
               emit_idx <= emit_idx + 5'h1;
         end
         else if (wcnt == 24'(WRITE_CYCLES - 1))
            programming <= 1'b0;
         else
            wcnt <= wcnt + 24'h1;
      end
   end

   // wrapped page writes start at the oldest surviving byte
   logic [3:0] slot;
   assign slot = (page_count == 5'(spdep_pkg::PAGE_BYTES))
                 ? word_addr[3:0] + emit_idx[3:0] : page_start + emit_idx[3:0];
   assign buf_in_valid = programming && emit_idx != page_count;
   assign buf_in_data = page_mem[slot];
   logic [7:0] buf_in_addr;
   assign buf_in_addr = {word_addr[7:4], slot};

   // address rides a twin buffer so a stalled byte keeps its own address
   spdep_buf u_addr_buf
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(buf_in_valid),
      .in_ready_out(),
      .in_data_in(buf_in_addr),
      .out_valid_out(),
      .out_ready_in(prog_ready_in),
      .out_data_out(prog_addr_out)
   );

   spdep_buf u_buf
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(buf_in_valid),
      .in_ready_out(buf_in_ready),
      .in_data_in(buf_in_data),
      .out_valid_out(prog_valid_out),
      .out_ready_in(prog_ready_in),
      .out_data_out(prog_data_out)
   );

   assign busy_out = programming;
   assign sda_out = 1'b0;
   assign sda_oe_out = ack_drive && ack_phase && !programming;

   a_busy_no_ack: assert property (@(posedge clk_in) disable iff (rst_in)
      programming |-> !ack_drive) else $error("ack driven while busy");
   a_perm_code_nack: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == spdep_pkg::ST_DEVADDR && scl_fall && bit_cnt == 4'h8
       && shift[7:4] == spdep_pkg::PROT_CODE && permanent_lock_in)
      |=> !sda_oe_out) else $error("protection code acked after permanent lock");
   a_wp_no_launch: assert property (@(posedge clk_in) disable iff (rst_in)
      (wp_sync[1] && state == spdep_pkg::ST_DATA && scl_fall && bit_cnt == 4'h8)
      |=> !write_ok) else $error("write allowed under protect pin");
   a_stop_launch: assert property (@(posedge clk_in) disable iff (rst_in)
      launch |=> programming) else $error("stop did not start programming");
   a_page_limit: assert property (@(posedge clk_in) disable iff (rst_in)
      page_count <= 5'(spdep_pkg::PAGE_BYTES)) else $error("page count overflow");
   a_start_addr: assert property (@(posedge clk_in) disable iff (rst_in || !por_done)
      (start_det && !programming) |=> state == spdep_pkg::ST_DEVADDR)
      else $error("start not honoured");
   a_stop_idle: assert property (@(posedge clk_in) disable iff (rst_in || !por_done)
      (stop_det && !start_det) |=> state == spdep_pkg::ST_IDLE)
      else $error("stop did not idle");
   // lower-half memory write under permanent lock not acked on data
   a_lock_nack: assert property (@(posedge clk_in) disable iff (rst_in)
      (state == spdep_pkg::ST_DATA && cmd == spdep_pkg::CMD_MEM && scl_fall
       && bit_cnt == 4'h8 && permanent_lock_in && !word_addr[7] && !programming)
      |=> !ack_drive) else $error("locked write acknowledged");
endmodule
